// ==== verilog/lbvf_defines.svh ====
`ifndef LBVF_DEFINES_SVH
`define LBVF_DEFINES_SVH
// register indexes, byte address is four times the index
`define LBVF_IDX_PIN 10'h0A4
`define LBVF_IDX_DEV1 10'h0A6
`define LBVF_IDX_DEV2 10'h0A8
`define LBVF_IDX_PERI 10'h0AA
`define LBVF_IDX_GD1 10'h0AC
`define LBVF_IDX_GD2 10'h0AE
`define LBVF_IDX_FLT2 10'h0A0
`define LBVF_IDX_STAT 10'h0C0
`define LBVF_IDX_MASK 10'h0C1
`define LBVF_IDX_CTRL 10'h0C2
`define LBVF_IDX_STATE 10'h0C3
// fault response field positions
`define LBVF_NOMTR_EN_BIT 28
`define LBVF_NOMTR_THR_LSB 19
`define LBVF_LOCK_ACT_LSB 15
`define LBVF_LOCK_DEG_LSB 12
`define LBVF_UV_LVL_LSB 8
`define LBVF_UV_REC_BIT 7
`define LBVF_OV_LVL_LSB 4
`define LBVF_OV_REC_BIT 3
`define LBVF_RETRY_LSB 0
// status bit positions
`define LBVF_ST_LOCK 0
`define LBVF_ST_LATCH 1
`define LBVF_ST_UV 2
`define LBVF_ST_OV 3
`define LBVF_ST_NOMTR 4
// reset values
`define LBVF_CFG_RST 32'h00000000
`define LBVF_MASK_RST 5'h00
// timing
`define LBVF_CLK_MHZ 250
`define LBVF_LOCK_WAIT_US 1000
`endif

// ==== verilog/lbvf_pkg.sv ====
package lbvf_pkg;
    // driver state requested from the power stage
    typedef enum logic [1:0] {
        LBVF_DRV_RUN = 2'b00,
        LBVF_DRV_TRI = 2'b01,
        LBVF_DRV_HSB = 2'b10,
        LBVF_DRV_LSB = 2'b11
    } lbvf_gate_t;
    // current-limit lock sequencer states
    typedef enum logic [1:0] {
        LBVF_LK_IDLE = 2'b00,
        LBVF_LK_WAIT = 2'b01,
        LBVF_LK_LATCH = 2'b10
    } lbvf_lock_st_t;
    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lbvf_apb_req_t;
    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } lbvf_apb_rsp_t;
    // measurements and detector from the power stage
    typedef struct packed {
        logic ilimit_lock;
        logic drive_active;
        logic [15:0] phase_current_ma;
        logic [15:0] bus_voltage_mv;
    } lbvf_sense_t;
    // whole state of the block
    typedef struct packed {
        logic [5:0][31:0] cfg;
        logic [31:0] fault2;
        logic [4:0] status;
        logic [4:0] mask;
        lbvf_lock_st_t lock_st;
        logic [10:0] deg_cnt;
        logic deg_armed;
        logic [23:0] wait_cnt;
        logic [4:0] retries;
        logic uv;
        logic ov;
        logic nomtr;
        lbvf_gate_t gate;
        logic fault_n;
        logic irq;
        lbvf_apb_rsp_t rsp;
    } lbvf_state_t;
endpackage : lbvf_pkg

// ==== verilog/lbvf_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lbvf_defines.svh"
module lbvf_top #(
    // cycles spent waiting before an automatic lock retry
    parameter int RETRY_WAIT_CYC = `LBVF_LOCK_WAIT_US * `LBVF_CLK_MHZ
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire lbvf_pkg::lbvf_apb_req_t apb_req,
    output var lbvf_pkg::lbvf_apb_rsp_t apb_rsp,
    // power stage sense
    input wire lbvf_pkg::lbvf_sense_t sense,
    // fault reaction
    output var lbvf_pkg::lbvf_gate_t gate_mode,
    output logic fault_output_n,
    output logic irq
);
    import lbvf_pkg::*;

    localparam logic [10:0] CYC_PER_US = 11'(`LBVF_CLK_MHZ);
    localparam logic [23:0] WAIT_LAST = 24'(RETRY_WAIT_CYC - 1);

    // registered state and its next value
    lbvf_state_t q;
    lbvf_state_t next_q;

    // no-motor threshold in milliamps
    function automatic logic [15:0] nomtr_thr(input logic [2:0] c);
        case (c)
            3'h2: nomtr_thr = 16'h0064;
            3'h3: nomtr_thr = 16'h007D;
            3'h4: nomtr_thr = 16'h00FA;
            3'h5: nomtr_thr = 16'h01F4;
            3'h6: nomtr_thr = 16'h02EE;
            3'h7: nomtr_thr = 16'h03E8;
            default: nomtr_thr = 16'h004B;
        endcase
    endfunction : nomtr_thr

    // undervoltage level in millivolts, zero means no limit
    function automatic logic [15:0] uv_thr(input logic [2:0] c);
        case (c)
            3'h1: uv_thr = 16'h1194;
            3'h2: uv_thr = 16'h1388;
            3'h3: uv_thr = 16'h157C;
            3'h4: uv_thr = 16'h1770;
            3'h5: uv_thr = 16'h1D4C;
            3'h6: uv_thr = 16'h2710;
            3'h7: uv_thr = 16'h30D4;
            default: uv_thr = 16'h0000;
        endcase
    endfunction : uv_thr

    // overvoltage level in millivolts, zero means no limit
    function automatic logic [15:0] ov_thr(input logic [2:0] c);
        case (c)
            3'h1: ov_thr = 16'h4E20;
            3'h2: ov_thr = 16'h57E4;
            3'h3: ov_thr = 16'h61A8;
            3'h4: ov_thr = 16'h6B6C;
            3'h5: ov_thr = 16'h7530;
            3'h6: ov_thr = 16'h7EF4;
            3'h7: ov_thr = 16'h88B8;
            default: ov_thr = 16'h0000;
        endcase
    endfunction : ov_thr

    // allowed automatic retries, zero means unlimited
    function automatic logic [4:0] retry_max(input logic [2:0] c);
        case (c)
            3'h1: retry_max = 5'h02;
            3'h2: retry_max = 5'h03;
            3'h3: retry_max = 5'h05;
            3'h4: retry_max = 5'h07;
            3'h5: retry_max = 5'h0A;
            3'h6: retry_max = 5'h0F;
            3'h7: retry_max = 5'h14;
            default: retry_max = 5'h00;
        endcase
    endfunction : retry_max

    // driver state held by a latched lock fault
    function automatic lbvf_gate_t lock_gate(input logic [3:0] a);
        case (a[1:0])
            2'b10: lock_gate = LBVF_DRV_HSB;
            2'b11: lock_gate = LBVF_DRV_LSB;
            default: lock_gate = LBVF_DRV_TRI;
        endcase
    endfunction : lock_gate

    // field views of the fault response word, live comparisons, bus decode and events
    logic [3:0] act;
    logic [2:0] deg_code;
    logic [10:0] deg_need;
    logic [4:0] rmax;
    logic uv_now;
    logic ov_now;
    logic nomtr_now;
    logic lock_evt;
    logic setup;
    logic wr;
    logic hit;
    logic [9:0] idx;
    logic [31:0] rdata;
    logic clr;
    logic [4:0] evt;

    // field decode and live comparisons
    always_comb begin
        act = q.fault2[`LBVF_LOCK_ACT_LSB +: 4];
        deg_code = q.fault2[`LBVF_LOCK_DEG_LSB +: 3];
        deg_need = 11'(deg_code * CYC_PER_US);
        rmax = retry_max(q.fault2[`LBVF_RETRY_LSB +: 3]);
        uv_now = (q.fault2[`LBVF_UV_LVL_LSB +: 3] != 3'h0)
            && (sense.bus_voltage_mv < uv_thr(q.fault2[`LBVF_UV_LVL_LSB +: 3]));
        ov_now = (q.fault2[`LBVF_OV_LVL_LSB +: 3] != 3'h0)
            && (sense.bus_voltage_mv > ov_thr(q.fault2[`LBVF_OV_LVL_LSB +: 3]));
        nomtr_now = q.fault2[`LBVF_NOMTR_EN_BIT] && sense.drive_active
            && (sense.phase_current_ma < nomtr_thr(q.fault2[`LBVF_NOMTR_THR_LSB +: 3]));
        // codes 9 and up never fire
        lock_evt = sense.ilimit_lock && (act < 4'h9) && q.deg_armed
            && (q.deg_cnt >= deg_need);
    end

    // apb address decode and read mux
    always_comb begin
        setup = apb_req.psel && !apb_req.penable;
        wr = apb_req.psel && apb_req.penable && q.rsp.pready
            && apb_req.pwrite && !q.rsp.pslverr;
        idx = apb_req.paddr[11:2];
        hit = 1'b1;
        rdata = 32'h00000000;
        if (apb_req.paddr[1:0] != 2'b00) begin
            // only whole aligned words are mapped
            hit = 1'b0;
        end else if (idx == `LBVF_IDX_PIN) begin
            // pin setup word, plain storage
            rdata = q.cfg[0];
        end else if (idx == `LBVF_IDX_DEV1) begin
            // first device setup word
            rdata = q.cfg[1];
        end else if (idx == `LBVF_IDX_DEV2) begin
            // second device setup word
            rdata = q.cfg[2];
        end else if (idx == `LBVF_IDX_PERI) begin
            // peripheral setup word
            rdata = q.cfg[3];
        end else if (idx == `LBVF_IDX_GD1) begin
            // first gate drive setup word
            rdata = q.cfg[4];
        end else if (idx == `LBVF_IDX_GD2) begin
            // second gate drive setup word
            rdata = q.cfg[5];
        end else if (idx == `LBVF_IDX_FLT2) begin
            // fault response word that steers this block
            rdata = q.fault2;
        end else if (idx == `LBVF_IDX_STAT) begin
            // sticky event bits
            rdata = {27'h0000000, q.status};
        end else if (idx == `LBVF_IDX_MASK) begin
            // interrupt enables, same layout as status
            rdata = {27'h0000000, q.mask};
        end else if (idx == `LBVF_IDX_CTRL) begin
            // write-only, reads zero
            rdata = 32'h00000000;
        end else if (idx == `LBVF_IDX_STATE) begin
            // live fault picture, read only
            rdata = {19'h00000, q.retries, q.nomtr, q.ov, q.uv,
                q.lock_st, q.gate, q.fault_n};
        end else begin
            // unmapped index answers with an error
            hit = 1'b0;
        end
        // fault clear strobe
        clr = wr && (idx == `LBVF_IDX_CTRL) && apb_req.pwdata[0];
    end

    // next state of the whole block
    always_comb begin
        next_q = q;
        evt = 5'h00;
        // apb answer: zero wait, ready in first access cycle
        next_q.rsp.pready = setup;
        next_q.rsp.pslverr = setup && !hit;
        next_q.rsp.prdata = setup ? rdata : 32'h00000000;
        // register writes
        if (wr) begin
            if (idx == `LBVF_IDX_PIN) begin
                // pin setup, no effect here
                next_q.cfg[0] = apb_req.pwdata;
            end else if (idx == `LBVF_IDX_DEV1) begin
                // first device setup, no effect here
                next_q.cfg[1] = apb_req.pwdata;
            end else if (idx == `LBVF_IDX_DEV2) begin
                // second device setup, no effect here
                next_q.cfg[2] = apb_req.pwdata;
            end else if (idx == `LBVF_IDX_PERI) begin
                // peripheral setup, no effect here
                next_q.cfg[3] = apb_req.pwdata;
            end else if (idx == `LBVF_IDX_GD1) begin
                // first gate drive setup, no effect here
                next_q.cfg[4] = apb_req.pwdata;
            end else if (idx == `LBVF_IDX_GD2) begin
                // second gate drive setup, no effect here
                next_q.cfg[5] = apb_req.pwdata;
            end else if (idx == `LBVF_IDX_FLT2) begin
                // new fault response takes hold next cycle
                next_q.fault2 = apb_req.pwdata;
            end else if (idx == `LBVF_IDX_STAT) begin
                // write one to clear
                next_q.status = q.status & ~apb_req.pwdata[4:0];
            end else if (idx == `LBVF_IDX_MASK) begin
                // interrupt enables, upper bits dropped
                next_q.mask = apb_req.pwdata[4:0];
            end
        end

        // deglitch counter, one event per assertion
        if (!sense.ilimit_lock || (act >= 4'h9)) begin
            // detector quiet or detection off: rearm
            next_q.deg_cnt = 11'h000;
            next_q.deg_armed = 1'b1;
        end else if (lock_evt) begin
            // fired once, wait for the detector to drop
            next_q.deg_armed = 1'b0;
        end else if (q.deg_cnt < deg_need) begin
            // still filtering, count one more cycle
            next_q.deg_cnt = q.deg_cnt + 11'h001;
        end

        if (clr) begin
            next_q.lock_st = LBVF_LK_IDLE;
            next_q.retries = 5'h00;
        end

        // lock sequencer
        case (q.lock_st)
            LBVF_LK_IDLE: begin
                if (lock_evt) begin
                    evt[`LBVF_ST_LOCK] = 1'b1;
                    if (act == 4'h8) begin
                        next_q.lock_st = LBVF_LK_IDLE;
                    end else if (act < 4'h4) begin
                        next_q.lock_st = LBVF_LK_LATCH;
                        evt[`LBVF_ST_LATCH] = 1'b1;
                    end else if ((rmax != 5'h00) && (q.retries >= rmax)) begin
                        next_q.lock_st = LBVF_LK_LATCH;
                        evt[`LBVF_ST_LATCH] = 1'b1;
                    end else begin
                        next_q.lock_st = LBVF_LK_WAIT;
                        next_q.wait_cnt = 24'h000000;
                        if (q.retries != 5'h1F) begin
                            next_q.retries = q.retries + 5'h01;
                        end
                    end
                end
            end
            LBVF_LK_WAIT: begin
                if (!clr) begin
                    // count the wait, leave at its last cycle
                    next_q.wait_cnt = q.wait_cnt + 24'h000001;
                    if (q.wait_cnt >= WAIT_LAST) begin
                        next_q.lock_st = LBVF_LK_IDLE;
                    end
                end
            end
            LBVF_LK_LATCH: begin
                if (!clr) begin
                    next_q.lock_st = LBVF_LK_LATCH;
                end
            end
            default: begin
                // unused code falls back to idle
                next_q.lock_st = LBVF_LK_IDLE;
            end
        endcase

        if (clr || (q.fault2[`LBVF_UV_REC_BIT] && !uv_now)) begin
            // released by clear or by recovery in bounds
            next_q.uv = 1'b0;
        end
        if (uv_now) begin
            // a present condition wins over any release
            next_q.uv = 1'b1;
            evt[`LBVF_ST_UV] = !q.uv;
        end

        if (clr || (q.fault2[`LBVF_OV_REC_BIT] && !ov_now)) begin
            // released by clear or by recovery in bounds
            next_q.ov = 1'b0;
        end
        if (ov_now) begin
            // a present condition wins over any release
            next_q.ov = 1'b1;
            evt[`LBVF_ST_OV] = !q.ov;
        end

        next_q.nomtr = nomtr_now;
        evt[`LBVF_ST_NOMTR] = nomtr_now && !q.nomtr;

        // sticky status, a new event wins over the clear
        next_q.status = next_q.status | evt;

        // driver state from the fault picture
        if (next_q.lock_st == LBVF_LK_LATCH) begin
            next_q.gate = lock_gate(act);
        end else if ((next_q.lock_st == LBVF_LK_WAIT) || next_q.uv || next_q.ov) begin
            // retry wait or bus voltage fault: float the bridge
            next_q.gate = LBVF_DRV_TRI;
        end else begin
            // no fault held, motor may run
            next_q.gate = LBVF_DRV_RUN;
        end
        // fault pin active while a lock, undervoltage or overvoltage fault is held
        next_q.fault_n = !((next_q.lock_st != LBVF_LK_IDLE) || next_q.uv || next_q.ov);
        next_q.irq = |(next_q.status & next_q.mask);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // all fields to their reset values
            q <= '0;
            q.cfg <= {6{`LBVF_CFG_RST}};
            q.fault2 <= `LBVF_CFG_RST;
            q.mask <= `LBVF_MASK_RST;
            q.deg_armed <= 1'b1;
            q.fault_n <= 1'b1;
            q.gate <= LBVF_DRV_RUN;
            q.lock_st <= LBVF_LK_IDLE;
        end else begin
            // take the whole next picture at once
            q <= next_q;
        end
    end

    // outputs straight from the state flops
    assign apb_rsp = q.rsp;
    assign gate_mode = q.gate;
    assign fault_output_n = q.fault_n;
    assign irq = q.irq;
endmodule : lbvf_top
`default_nettype wire

// ==== tb/lbvf_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module lbvf_monitor #(
    parameter int RETRY_WAIT_CYC = 20
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus and sense
    input wire lbvf_pkg::lbvf_apb_req_t apb_req,
    input wire lbvf_pkg::lbvf_apb_rsp_t apb_rsp,
    input wire lbvf_pkg::lbvf_sense_t sense,
    // reaction
    input wire lbvf_pkg::lbvf_gate_t gate_mode,
    input wire logic fault_output_n,
    input wire logic irq
);
    import lbvf_pkg::*;
    logic [31:0] cfg; // shadow of fault_response_setup_two
    logic [3:0] act; // lock action code
    // follow completed writes to the fault word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= 32'h00000000;
        end else if (apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
            && apb_req.paddr == 12'h280) begin
            cfg <= apb_req.pwdata;
        end
    end
    assign act = cfg[18:15];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no ready after setup");
    a_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held too long");
    a_misalign_err: assert property (apb_req.psel && !apb_req.penable
        && apb_req.paddr[1:0] != 2'h0 |=> apb_rsp.pslverr) else $error("misaligned accepted");
    a_reset_run: assert property ($rose(presetn) |-> gate_mode == LBVF_DRV_RUN
        && fault_output_n && !irq) else $error("outputs not idle after reset");
    a_hsb_code: assert property (gate_mode == LBVF_DRV_HSB |-> act == 4'h2 || act == 4'h6)
        else $error("high brake with wrong code");
    a_lsb_code: assert property (gate_mode == LBVF_DRV_LSB |-> act == 4'h3 || act == 4'h7)
        else $error("low brake with wrong code");
    a_hsb_react: assert property (act == 4'h2 && cfg[14:12] == 3'h0
        && $rose(sense.ilimit_lock) |=> gate_mode == LBVF_DRV_HSB && !fault_output_n)
        else $error("lock not braked at once");
    a_deglitch_wait: assert property (act inside {4'h2, 4'h3} && cfg[14:12] != 3'h0
        && $rose(sense.ilimit_lock) && gate_mode == LBVF_DRV_RUN |=> gate_mode == LBVF_DRV_RUN)
        else $error("lock acted before deglitch");
    a_report_quiet: assert property (act >= 4'h8 && cfg[10:8] == 3'h0
        && cfg[6:4] == 3'h0 && gate_mode == LBVF_DRV_RUN && fault_output_n
        |=> gate_mode == LBVF_DRV_RUN && fault_output_n) else $error("action in report mode");
    a_brake_holds: assert property (gate_mode inside {LBVF_DRV_HSB, LBVF_DRV_LSB}
        && !apb_req.psel && !$past(apb_req.psel) |=> $stable(gate_mode))
        else $error("brake released without clear");
    a_uv_trip: assert property (cfg[10:8] == 3'h7 && sense.bus_voltage_mv < 16'h30D4
        |-> ##[1:2] !fault_output_n) else $error("undervoltage missed");
    a_ov_trip: assert property (cfg[6:4] == 3'h7 && sense.bus_voltage_mv > 16'h88B8
        |-> ##[1:2] !fault_output_n) else $error("overvoltage missed");
    // main scenarios seen
    c_low_brake: cover property (gate_mode == LBVF_DRV_LSB);
    c_fault_pin: cover property ($fell(fault_output_n));
    c_irq: cover property ($rose(irq));
endmodule : lbvf_monitor
bind lbvf_top lbvf_monitor #(.RETRY_WAIT_CYC(RETRY_WAIT_CYC)) mon (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sense(sense),
    .gate_mode(gate_mode), .fault_output_n(fault_output_n), .irq(irq));
`default_nettype wire

// ==== tb/lbvf_stage_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module lbvf_stage_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // commanded conditions
    input wire logic lock_req,
    input wire logic spin,
    input wire logic [15:0] load_ma,
    input wire logic [15:0] supply_mv,
    // measurements toward the block
    output var lbvf_pkg::lbvf_sense_t sense
);
    import lbvf_pkg::*;
    // converters and detector report one cycle late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense <= '0;
        end else begin
            sense <= '{lock_req, spin, load_ma, supply_mv};
        end
    end
endmodule : lbvf_stage_model
`default_nettype wire

// ==== tb/lock_and_bus_voltage_fault_config_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module lock_and_bus_voltage_fault_config_test;
    import lbvf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    lbvf_apb_req_t apb_req = '0;
    lbvf_apb_rsp_t apb_rsp;
    lbvf_sense_t sense;
    lbvf_gate_t gate_mode;
    logic fault_output_n, irq, perr;
    logic lock_req = 1'b0, spin = 1'b0;
    logic [15:0] load_ma = 16'h0000, supply_mv = 16'h5DC0; // 24 V
    logic [31:0] rdat;
    int n_fail = 0, comparisons = 0;
    // rows: action, gate, fault pin, lock status
    logic [7:0] tbl[7] = '{8'h05, 8'h15, 8'h29, 8'h3D, 8'h83, 8'h92, 8'hF2};
    lbvf_top #(.RETRY_WAIT_CYC(20)) DUT (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .sense(sense), .gate_mode(gate_mode),
        .fault_output_n(fault_output_n), .irq(irq));
    lbvf_stage_model stage (.pclk(pclk), .presetn(presetn), .lock_req(lock_req), .spin(spin),
        .load_ma(load_ma), .supply_mv(supply_mv), .sense(sense));
    initial begin
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    // one apb transfer, then an idle cycle
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (apb_rsp.pready !== 1'b1);
        chk(k, 1, "ready wait");
        rdat = apb_rsp.prdata;
        perr = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge pclk);
    endtask : bus
    task automatic pulse(input int n);
        lock_req <= 1'b1;
        wt(n);
        lock_req <= 1'b0;
        wt(3);
    endtask : pulse
    // clear latched faults and sticky status
    task automatic clr;
        bus(1, 12'h308, 32'h00000001);
        bus(1, 12'h300, 32'h0000001F);
        chk(fault_output_n, 1, "pin after clear");
    endtask : clr
    task automatic volt(input logic [31:0] c, input logic [15:0] bad, input logic exp);
        bus(1, 12'h280, c);
        supply_mv <= bad;
        wt(4);
        chk(fault_output_n, 0, "bus voltage trip");
        supply_mv <= 16'h5DC0;
        wt(4);
        chk(fault_output_n, exp, "bus recovery");
        clr;
    endtask : volt
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #100000;
        n_fail++;
        final_report;
    end
    initial begin
        wt(5);
        presetn <= 1'b1;
        wt(1);
        chk(gate_mode, LBVF_DRV_RUN, "gate at reset");
        bus(0, 12'h280, 0);
        chk(rdat, 32'h00000000, "fault word reset");
        bus(1, 12'h298, 32'hA5C3F00F);
        bus(0, 12'h298, 0);
        chk(rdat, 32'hA5C3F00F, "setup word");
        bus(0, 12'h2FC, 0);
        chk(perr, 1, "unmapped");
        bus(0, 12'h281, 0);
        chk(perr, 1, "misaligned");
        bus(1, 12'h304, 32'h0000001F);
        $display("registers done");
        foreach (tbl[i]) begin
            bus(1, 12'h280, {13'h0000, tbl[i][7:4], 15'h0000});
            pulse(4);
            chk(gate_mode, tbl[i][3:2], "gate");
            chk(fault_output_n, tbl[i][1], "pin held");
            bus(0, 12'h300, 0);
            chk(rdat[0], tbl[i][0], "lock status");
            chk(irq, tbl[i][0], "irq");
            clr;
            chk(irq, 0, "irq cleared");
        end
        $display("action table done");
        bus(1, 12'h280, 32'h00030001);
        for (int i = 0; i < 3; i++) begin
            pulse(4);
            chk(gate_mode, i < 2 ? LBVF_DRV_TRI : LBVF_DRV_HSB, "retry");
            wt(25);
            chk(gate_mode, i < 2 ? LBVF_DRV_RUN : LBVF_DRV_HSB, "retry end");
        end
        clr;
        $display("retry done");
        bus(1, 12'h280, 32'h00019000);
        pulse(200);
        chk(gate_mode, LBVF_DRV_RUN, "short lock");
        pulse(260);
        chk(gate_mode, LBVF_DRV_LSB, "long lock");
        clr;
        $display("deglitch done");
        bus(1, 12'h280, 32'h00000700);
        supply_mv <= 16'h30D4;
        wt(4);
        chk(fault_output_n, 1, "uv boundary");
        volt(32'h00000700, 16'h30D3, 0);
        volt(32'h00000180, 16'h1193, 1);
        volt(32'h00000078, 16'h88B9, 1);
        volt(32'h00000040, 16'h6B6D, 0);
        $display("voltage done");
        bus(1, 12'h280, 32'h10380000);
        spin <= 1'b1;
        load_ma <= 16'h03E7;
        wt(5);
        bus(0, 12'h300, 0);
        chk(rdat[4], 1, "no motor on");
        bus(1, 12'h280, 32'h00380000);
        bus(1, 12'h300, 32'h0000001F);
        wt(5);
        bus(0, 12'h300, 0);
        chk(rdat[4], 0, "no motor off");
        spin <= 1'b0;
        $display("no motor done");
        bus(1, 12'h280, 32'h00010000);
        pulse(4);
        chk(gate_mode, LBVF_DRV_HSB, "brake before reset");
        presetn <= 1'b0;
        wt(5);
        presetn <= 1'b1;
        wt(1);
        chk(fault_output_n, 1, "pin after reset");
        chk(gate_mode, LBVF_DRV_RUN, "gate after reset");
        bus(0, 12'h280, 0);
        chk(rdat, 32'h00000000, "fault word after reset");
        $display("mid-run reset done");
        final_report;
    end
endmodule : lock_and_bus_voltage_fault_config_test
`default_nettype wire
